// File: hw/kpd_pulse_dialer.sv
// keypad pulse dialer core with redial, AHB-Lite register slave
// ****************************************************************
// ****************************************************************
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`include "kpd_params.svh"

module kpd_pulse_dialer #(
   parameter int unsigned OSC_DIV_CYC  = `KPD_CLK_HZ / `KPD_OSC_HZ,
   parameter int unsigned DEBOUNCE_CYC = `KPD_DEBOUNCE_MS * (`KPD_CLK_HZ / 1000),
   parameter int unsigned ENTRY_CYC    = `KPD_ENTRY_MS * (`KPD_CLK_HZ / 1000),
   parameter int          DEPTH        = `KPD_DEPTH
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [3:0]  key_row,
   input  wire logic [2:0]  key_col,
   output logic             key_pull_en,
   input  wire logic        hook_switch_n,
   output logic             dial_pulse_n,
   output logic             mute_n,
   output logic             osc_run
);
   localparam int CW = $clog2(DEPTH + 1);

   if (OSC_DIV_CYC < 1 || DEPTH < 1 || DEPTH > 31) begin : g_bad
      $error("kpd_pulse_dialer: parameter out of range");
   end

   kpd_core_if #(.DEPTH(DEPTH)) core ();

   kpd_key_scan #(
      .DEBOUNCE_CYC (DEBOUNCE_CYC),
      .ENTRY_CYC    (ENTRY_CYC)
   ) u_scan (
      .mclk    (mclk),
      .reset_n (reset_n),
      .keyRow  (key_row),
      .keyCol  (key_col),
      .core    (core.scan)
   );

   kpd_digit_store #(.DEPTH(DEPTH)) u_store (
      .mclk    (mclk),
      .reset_n (reset_n),
      .core    (core.store)
   );

   // ****************************************************************
   // register slave
   // ****************************************************************
   logic [2:0]  ctrl_r;
   logic        wrPend_r;
   logic [7:0]  wrAddr_r;
   logic        addrPhase;
   logic [31:0] statusWord;

   logic                offHook;
   logic                oscTick;
   logic [31:0]         oscCnt_r;
   kpd_pkg::kpd_state_t state_r;
   logic [11:0]         phase_r;
   logic [3:0]          pulses_r;
   logic [CW-1:0]       rdPtr_r;
   logic                redial_r;
   logic                firstKey_r;
   logic                newNumber;
   logic                redialStart;
   logic                resume;
   logic                isPound;
   logic                dialing;
   logic                pending;

   assign addrPhase = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_comb begin
      statusWord = 32'h0;
      statusWord[`KPD_STAT_OFFHOOK] = offHook;
      statusWord[`KPD_STAT_DIALING] = dialing;
      statusWord[`KPD_STAT_OSC]     = osc_run;
      statusWord[`KPD_STAT_REDIAL]  = redial_r;
      statusWord[`KPD_STAT_HALTED]  = (state_r == kpd_pkg::ST_HALT);
      statusWord[`KPD_STAT_KEYDOWN] = core.keyDown;
      statusWord[`KPD_STAT_COUNT_LSB +: CW] = core.count;
      statusWord[`KPD_STAT_RDPTR_LSB +: CW] = rdPtr_r;
   end

   function automatic logic [31:0] readMux(input logic [7:0] a, input logic [2:0] c,
                                           input logic [31:0] s);
      if (a == `KPD_CTRL_OFS) begin
         return {29'h0, c};
      end else if (a == `KPD_STAT_OFS) begin
         return s;
      end
      return 32'h0;
   endfunction

   // read data is captured at the address phase, so the data phase needs no wait
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h0;
      end else if (addrPhase && !hwrite) begin
         hrdata <= readMux(haddr[7:0], ctrl_r, statusWord);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end else begin
         wrPend_r <= addrPhase && hwrite && haddr[31:8] == 24'h0;
         wrAddr_r <= haddr[7:0];
      end
   end

   // select bits steer rate, pause length and mark-to-space ratio
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `KPD_CTRL_RST;
      end else if (wrPend_r && wrAddr_r == `KPD_CTRL_OFS) begin
         ctrl_r <= hwdata[2:0];
      end
   end

   // ****************************************************************
   // gated oscillator
   // ****************************************************************
   assign offHook = !hook_switch_n;
   // a stale number must not restart by itself after off-hook; entries count only after this
   // session's first key, and the idle step between queued entries keeps mute low
   assign pending = !firstKey_r && rdPtr_r < core.count;
   assign dialing = (state_r == kpd_pkg::ST_IDLE) ? pending : (state_r != kpd_pkg::ST_HALT);

   // stopped on-hook and whenever no key is down and no dialing runs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         osc_run <= 1'b0;
      end else begin
         osc_run <= offHook && (core.keyDown || dialing);
      end
   end

   assign oscTick = osc_run && oscCnt_r == 32'(OSC_DIV_CYC - 1);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oscCnt_r <= 32'h0;
      end else if (!osc_run || oscTick) begin
         oscCnt_r <= 32'h0;
      end else begin
         oscCnt_r <= oscCnt_r + 32'h1;
      end
   end

   // ****************************************************************
   // key handling
   // ****************************************************************
   // scanning enabled whenever off-hook; pull networks only while a press is present
   assign core.scanEn = offHook;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         key_pull_en <= 1'b0;
      end else begin
         key_pull_en <= core.keyDown;
      end
   end

   assign isPound     = core.keyStrobe && core.keyCode == `KPD_KEY_POUND;
   assign redialStart = isPound && firstKey_r;
   assign newNumber   = core.keyStrobe && firstKey_r && !isPound
                        && core.keyCode != `KPD_KEY_STAR;
   assign resume      = isPound && !firstKey_r && state_r == kpd_pkg::ST_HALT;

   // digits, and pound as access pause, are stored in order
   always_comb begin
      core.clr    = newNumber;
      core.wrEn   = 1'b0;
      core.wrData = core.keyCode;
      if (core.keyStrobe && !redialStart && !redial_r && core.keyCode != `KPD_KEY_STAR) begin
         core.wrEn = 1'b1;
         if (isPound) begin
            core.wrData = `KPD_ENTRY_PAUSE;
         end
      end
   end

   // memory itself is untouched here; the number outlives on-hook
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         firstKey_r <= 1'b1;
         redial_r   <= 1'b0;
      end else if (!offHook) begin
         firstKey_r <= 1'b1;
         redial_r   <= 1'b0;
      end else if (core.keyStrobe && core.keyCode != `KPD_KEY_STAR) begin
         firstKey_r <= 1'b0;
         if (firstKey_r) begin
            redial_r <= isPound;
         end
      end
   end

   // ****************************************************************
   // pulse sequencer
   // ****************************************************************
   function automatic logic [11:0] phaseTicks(input logic fast, input logic ratio40,
                                              input logic brk);
      int period;
      int brkLen;
      period = fast ? `KPD_RATE_DIV_FAST : `KPD_RATE_DIV_SLOW;
      brkLen = ratio40 ? period * `KPD_BRK_NUM_4060 / `KPD_BRK_DEN_4060
                       : period * `KPD_BRK_NUM_3366 / `KPD_BRK_DEN_3366;
      return brk ? 12'(brkLen) : 12'(period - brkLen);
   endfunction

   function automatic logic [11:0] pauseTicks(input logic shortPause);
      return shortPause ? 12'(`KPD_PAUSE_SHORT) : 12'(`KPD_PAUSE_LONG);
   endfunction

   assign core.rdIdx = rdPtr_r;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r  <= kpd_pkg::ST_IDLE;
         phase_r  <= 12'h000;
         pulses_r <= 4'h0;
         rdPtr_r  <= '0;
      end else if (!offHook) begin
         state_r  <= kpd_pkg::ST_IDLE;
         phase_r  <= 12'h000;
         pulses_r <= 4'h0;
         rdPtr_r  <= '0;
      end else if (newNumber || redialStart) begin
         // leading pause before the first pulse
         state_r <= kpd_pkg::ST_PAUSE;
         phase_r <= pauseTicks(ctrl_r[`KPD_CTRL_PAUSE]);
         rdPtr_r <= '0;
      end else begin
         unique case (state_r)
            kpd_pkg::ST_IDLE: begin
               if (pending) begin
                  state_r <= kpd_pkg::ST_PAUSE;
                  phase_r <= pauseTicks(ctrl_r[`KPD_CTRL_PAUSE]);
               end
            end
            kpd_pkg::ST_PAUSE: begin
               if (oscTick) begin
                  phase_r <= phase_r - 12'h001;
                  if (phase_r == 12'h001) begin
                     if (core.rdData == `KPD_ENTRY_PAUSE) begin
                        if (redial_r) begin
                           state_r <= kpd_pkg::ST_HALT;
                        end else begin
                           state_r <= kpd_pkg::ST_IDLE;
                           rdPtr_r <= rdPtr_r + CW'(1);
                        end
                     end else begin
                        // digit value gives the pulse count, zero stored as ten
                        pulses_r <= core.rdData;
                        state_r  <= kpd_pkg::ST_BREAK;
                        phase_r  <= phaseTicks(ctrl_r[`KPD_CTRL_RATE],
                                               ctrl_r[`KPD_CTRL_RATIO], 1'b1);
                     end
                  end
               end
            end
            kpd_pkg::ST_BREAK: begin
               if (oscTick) begin
                  phase_r <= phase_r - 12'h001;
                  if (phase_r == 12'h001) begin
                     state_r <= kpd_pkg::ST_MAKE;
                     phase_r <= phaseTicks(ctrl_r[`KPD_CTRL_RATE],
                                           ctrl_r[`KPD_CTRL_RATIO], 1'b0);
                  end
               end
            end
            kpd_pkg::ST_MAKE: begin
               if (oscTick) begin
                  phase_r <= phase_r - 12'h001;
                  if (phase_r == 12'h001) begin
                     pulses_r <= pulses_r - 4'h1;
                     if (pulses_r > 4'h1) begin
                        state_r <= kpd_pkg::ST_BREAK;
                        phase_r <= phaseTicks(ctrl_r[`KPD_CTRL_RATE],
                                              ctrl_r[`KPD_CTRL_RATIO], 1'b1);
                     end else begin
                        state_r <= kpd_pkg::ST_IDLE;
                        rdPtr_r <= rdPtr_r + CW'(1);
                     end
                  end
               end
            end
            kpd_pkg::ST_HALT: begin
               if (resume) begin
                  state_r <= kpd_pkg::ST_IDLE;
                  rdPtr_r <= rdPtr_r + CW'(1);
               end
            end
            default: begin
               state_r <= kpd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // line outputs registered to keep them glitch free
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dial_pulse_n <= 1'b1;
         mute_n       <= 1'b1;
      end else begin
         dial_pulse_n <= !(offHook && state_r == kpd_pkg::ST_BREAK);
         mute_n       <= !(offHook && dialing);
      end
   end
endmodule

// File: common/kpd_params.svh
// constants for the keypad pulse dialer: offsets, field positions, reset values, timing
`ifndef KPD_PARAMS_SVH
`define KPD_PARAMS_SVH

// ****************************************************************
// time base
// ****************************************************************
`define KPD_CLK_HZ          100000000
`define KPD_OSC_HZ          2400
`define KPD_DEBOUNCE_MS     20
`define KPD_ENTRY_MS        50

// ****************************************************************
// dialing figures: times in oscillator cycles, break ratios, memory depth in entries
// ****************************************************************
`define KPD_RATE_DIV_SLOW   240
`define KPD_RATE_DIV_FAST   120
`define KPD_PAUSE_LONG      1920
`define KPD_PAUSE_SHORT     960
`define KPD_BRK_NUM_3366    2
`define KPD_BRK_DEN_3366    3
`define KPD_BRK_NUM_4060    3
`define KPD_BRK_DEN_4060    5
`define KPD_DEPTH           20

// ****************************************************************
// key codes and stored entry codes
// ****************************************************************
`define KPD_KEY_ZERO        4'ha
`define KPD_KEY_STAR        4'hb
`define KPD_KEY_POUND       4'hc
`define KPD_ENTRY_PAUSE     4'hf

// ****************************************************************
// register map
// ****************************************************************
`define KPD_CTRL_OFS        8'h00
`define KPD_STAT_OFS        8'h04
`define KPD_CTRL_RATE       0
`define KPD_CTRL_PAUSE      1
`define KPD_CTRL_RATIO      2
`define KPD_CTRL_RST        3'h0
`define KPD_STAT_OFFHOOK    0
`define KPD_STAT_DIALING    1
`define KPD_STAT_OSC        2
`define KPD_STAT_REDIAL     3
`define KPD_STAT_HALTED     4
`define KPD_STAT_KEYDOWN    5
`define KPD_STAT_COUNT_LSB  8
`define KPD_STAT_RDPTR_LSB  16

`endif

// File: common/kpd_pkg.sv
// types shared by the keypad pulse dialer modules
package kpd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PAUSE,
      ST_BREAK,
      ST_MAKE,
      ST_HALT
   } kpd_state_t;

   typedef logic [3:0] kpd_entry_t;
endpackage

// File: common/kpd_core_if.sv
// signals between the dialer core, the key scanner and the number store
interface kpd_core_if #(
   parameter int DEPTH = 20,
   parameter int CW    = $clog2(DEPTH + 1)
);
   logic                scanEn;
   logic                keyDown;
   logic                keyStrobe;
   kpd_pkg::kpd_entry_t keyCode;
   logic                wrEn;
   logic                clr;
   kpd_pkg::kpd_entry_t wrData;
   logic [CW-1:0]       rdIdx;
   kpd_pkg::kpd_entry_t rdData;
   logic [CW-1:0]       count;

   modport scan  (input scanEn, output keyDown, keyStrobe, keyCode);
   modport store (input wrEn, clr, wrData, rdIdx, output rdData, count);
   modport ctrl  (output scanEn, wrEn, clr, wrData, rdIdx,
                  input keyDown, keyStrobe, keyCode, rdData, count);
endinterface

// File: hw/kpd_key_scan.sv
// keypad scanner with debounce and entry spacing
`include "kpd_params.svh"

module kpd_key_scan #(
   parameter int unsigned DEBOUNCE_CYC = 2000000,
   parameter int unsigned ENTRY_CYC    = 5000000
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [3:0] keyRow,
   input  wire logic [2:0] keyCol,
   kpd_core_if.scan        core
);
   if (DEBOUNCE_CYC < 1 || ENTRY_CYC < 1) begin : g_bad
      $error("kpd_key_scan: counts must be at least one cycle");
   end

   logic [4:0]  dec;
   logic [4:0]  last_r;
   logic [31:0] stableCnt_r;
   logic [31:0] gapCnt_r;
   logic        taken_r;
   logic        keyDown;
   logic        fire;

   // returns {valid, code}; two keys at once give no code
   function automatic logic [4:0] decodeKey(input logic [3:0] r, input logic [2:0] c);
      logic [3:0] n;
      n = 4'h0;
      if ($onehot(r) && $onehot(c)) begin
         for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 3; j++) begin
               if (r[i] && c[j]) begin
                  n = 4'(i * 3 + j + 1);
               end
            end
         end
         if (n == 4'ha) begin
            n = `KPD_KEY_STAR;
         end else if (n == 4'hb) begin
            n = `KPD_KEY_ZERO;
         end
         return {1'b1, n};
      end
      return 5'h00;
   endfunction

   // a closure is a row and a column both high together
   assign keyDown      = core.scanEn & (|keyRow) & (|keyCol);
   assign core.keyDown = keyDown;
   assign dec          = decodeKey(keyRow, keyCol);
   assign fire         = keyDown && dec[4] && dec == last_r && !taken_r && gapCnt_r == 32'h0
                         && stableCnt_r == 32'(DEBOUNCE_CYC - 1);

   // any change of code restarts the stability count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         last_r      <= 5'h00;
         stableCnt_r <= 32'h0;
      end else if (!keyDown || dec != last_r) begin
         last_r      <= dec;
         stableCnt_r <= 32'h0;
      end else if (stableCnt_r != 32'(DEBOUNCE_CYC - 1)) begin
         stableCnt_r <= stableCnt_r + 32'h1;
      end
   end

   // one entry per press; held key does not repeat
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         taken_r <= 1'b0;
      end else if (!keyDown) begin
         taken_r <= 1'b0;
      end else if (fire) begin
         taken_r <= 1'b1;
      end
   end

   // entries are spaced by the entry interval
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gapCnt_r <= 32'h0;
      end else if (fire) begin
         gapCnt_r <= 32'(ENTRY_CYC - 1);
      end else if (gapCnt_r != 32'h0) begin
         gapCnt_r <= gapCnt_r - 32'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core.keyStrobe <= 1'b0;
         core.keyCode   <= 4'h0;
      end else begin
         core.keyStrobe <= fire;
         if (fire) begin
            core.keyCode <= dec[3:0];
         end
      end
   end
endmodule

// File: hw/kpd_digit_store.sv
// number memory: entries in order, kept until a new number replaces them
module kpd_digit_store #(
   parameter int DEPTH = 20,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   kpd_core_if.store core
);
   if (DEPTH < 1 || DEPTH > 31) begin : g_bad
      $error("kpd_digit_store: DEPTH out of range");
   end

   // memory itself has no reset so the number survives on-hook
   kpd_pkg::kpd_entry_t mem [DEPTH];
   logic [CW-1:0]       count_r;
   logic [CW-1:0]       wrIdx;

   assign wrIdx       = core.clr ? '0 : count_r;
   assign core.count  = count_r;
   assign core.rdData = (core.rdIdx < CW'(DEPTH)) ? mem[core.rdIdx] : 4'h0;

   always_ff @(posedge mclk) begin
      if (core.wrEn && wrIdx < CW'(DEPTH)) begin
         mem[wrIdx] <= core.wrData;
      end
   end

   // entries beyond the capacity are dropped
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= '0;
      end else if (core.wrEn && wrIdx < CW'(DEPTH)) begin
         count_r <= wrIdx + CW'(1);
      end else if (core.clr) begin
         count_r <= '0;
      end
   end
endmodule

// File: tb/kpd_keypad_model.sv
// keypad partner: logic gates raising one row and one column per key
`include "kpd_params.svh"

module kpd_keypad_model (
   input  wire logic       press,
   input  wire logic [3:0] code,
   output logic      [3:0] keyRow,
   output logic      [2:0] keyCol
);
   timeunit 1ns;
   timeprecision 1ps;
   int idx;
   always_comb begin
      case (code)
         `KPD_KEY_STAR:  idx = 9;
         `KPD_KEY_ZERO:  idx = 10;
         `KPD_KEY_POUND: idx = 11;
         default:        idx = int'(code) - 1;
      endcase
      // gates drive low between keys, so idle lines are defined
      keyRow = press ? 4'h1 << (idx / 3) : 4'h0;
      keyCol = press ? 3'h1 << (idx % 3) : 3'h0;
   end
endmodule

// File: tb/kpd_pulse_dialer_properties.sv
// port checker for the pulse dialer
module kpd_pulse_dialer_properties (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic [3:0] key_row,
   input wire logic       key_pull_en,
   input wire logic       hook_switch_n,
   input wire logic       dial_pulse_n,
   input wire logic       mute_n,
   input wire logic       osc_run
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   bus_okay_a:
      assert property (hreadyout && !hresp) else $error("bus answer not okay");
   onhook_quiet_a:
      assert property (hook_switch_n[*4] |-> mute_n && dial_pulse_n && !osc_run)
         else $error("activity while on hook");
   brk_mute_a:
      assert property (!dial_pulse_n |-> !mute_n) else $error("break without mute");
   dial_osc_a:
      assert property (!mute_n |-> osc_run) else $error("dialing without oscillator");
   brk_len_a:
      assert property ($fell(dial_pulse_n) |-> !dial_pulse_n[*8]) else $error("short break");
   pause_lead_a:
      assert property ($fell(mute_n) |-> dial_pulse_n[*8]) else $error("no leading pause");
   osc_stop_a:
      assert property ((!key_pull_en && mute_n)[*4] |-> !osc_run) else $error("idle osc runs");
   pull_idle_a:
      assert property ((key_row == 4'h0)[*3] |-> !key_pull_en) else $error("pull without key");
endmodule

bind kpd_pulse_dialer kpd_pulse_dialer_properties u_props (
   .mclk(mclk), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
   .key_row(key_row), .key_pull_en(key_pull_en), .hook_switch_n(hook_switch_n),
   .dial_pulse_n(dial_pulse_n), .mute_n(mute_n), .osc_run(osc_run));

// File: tb/tb_keypad_pulse_dialer.sv
// self-checking bench for the pulse dialer
`include "kpd_params.svh"

module tb_keypad_pulse_dialer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4;
   typedef struct {logic [2:0] ctrl; logic [3:0] dig; int pulses, brk, lead;} kpd_case_t;
   kpd_case_t   rows [4] = '{'{3'h3, 4'h3, 3, 80, 960}, '{3'h7, `KPD_KEY_ZERO, 10, 72, 960},
                             '{3'h0, 4'h1, 1, 160, 1920}, '{3'h5, 4'h2, 2, 72, 1920}};
   logic        mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, hookN = 1, press = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2, keyCol;
   logic [3:0]  code = 0, keyRow;
   logic        hreadyout, hresp, pullEn, dpN, muteN, oscRun;
   int          num_errors = 0, n_compared = 0, cyc = 0, np, bw, ld;

   kpd_pulse_dialer #(.OSC_DIV_CYC(DIV), .DEBOUNCE_CYC(8), .ENTRY_CYC(16), .DEPTH(20)) DUT (
      .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_row(keyRow),
      .key_col(keyCol), .key_pull_en(pullEn), .hook_switch_n(hookN),
      .dial_pulse_n(dpN), .mute_n(muteN), .osc_run(oscRun));
   kpd_keypad_model pad (.press(press), .code(code), .keyRow(keyRow), .keyCol(keyCol));

   always #5 mclk = ~mclk;
   // about 60k cycles are needed; the ceiling leaves margin
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 100000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic key(input logic [3:0] c, input int hold);
      code <= c;
      press <= 1'b1;
      repeat (hold) @(posedge mclk);
      press <= 1'b0;
      repeat (24) @(posedge mclk);
   endtask

   task automatic hook(input logic v);
      hookN <= v;
      repeat (6) @(posedge mclk);
   endtask

   // counts breaks, break cycles and the lead-in until mute releases
   task automatic watch;
      logic prev;
      int   n;
      prev = 1'b1;
      n = 0;
      np = 0;
      bw = 0;
      ld = 0;
      while (muteN !== 1'b0 && n < 20000) begin
         @(posedge mclk);
         n++;
      end
      while (muteN === 1'b0) begin
         @(posedge mclk);
         if (dpN === 1'b0 && prev === 1'b1) np++;
         if (dpN === 1'b0) bw++;
         if (np == 0) ld++;
         prev = dpN;
      end
   endtask

   task automatic dial(input logic [3:0] c);
      fork
         key(c, 12);
         watch();
      join
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd === 32'h0, "ctrl reset value");
      ahb(1'b1, 32'h0, 32'h5);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd === 32'h5, "ctrl readback");
      ahb(1'b0, 32'h8, 32'h0);
      check(rd === 32'h0, "unmapped read");
      key(4'h5, 20);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[12:8] === 5'h0 && oscRun === 1'b0, "on-hook key taken");
      hook(1'b0);
      key(4'h5, 4);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[12:8] === 5'h0 && rd[0] === 1'b1, "bounce taken");
      hook(1'b1);
      $display("register and entry tests done");
      foreach (rows[i]) begin
         ahb(1'b1, 32'h0, {29'h0, rows[i].ctrl});
         hook(1'b0);
         dial(rows[i].dig);
         check(np == rows[i].pulses, "pulse count");
         check(bw >= np * (rows[i].brk * DIV - 1) && bw <= np * (rows[i].brk * DIV + 1),
               "break length");
         check(ld >= rows[i].lead * DIV - 4 && ld <= rows[i].lead * DIV + 4,
               "leading pause");
         hook(1'b1);
         $display("dial row %0d done", i);
      end
      ahb(1'b1, 32'h0, 32'h3);
      hook(1'b0);
      fork
         begin
            key(4'h1, 12);
            key(`KPD_KEY_POUND, 12);
            key(4'h2, 12);
         end
         watch();
      join
      check(np == 3, "queued entries");
      hook(1'b1);
      hook(1'b0);
      dial(`KPD_KEY_POUND);
      check(np == 1, "redial to pause");
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[4] === 1'b1 && rd[3] === 1'b1, "halted flag");
      dial(`KPD_KEY_POUND);
      check(np == 2, "redial resumed");
      hook(1'b1);
      $display("queue and redial tests done");
      hook(1'b0);
      key(4'h1, 12);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[12:8] === 5'h1, "new number");
      repeat (20) key(4'h1, 12);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[12:8] === 5'h14, "memory limit");
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      check(muteN === 1'b1 && dpN === 1'b1 && oscRun === 1'b0, "mid-run reset");
      ahb(1'b0, 32'h4, 32'h0);
      check(rd[12:8] === 5'h0 && rd[1] === 1'b0, "reset clears state");
      hook(1'b1);
      $display("memory tests done");
      end_sim();
   end
endmodule
